// [rxcd_regs.svh]
// rxcd_regs.svh: code-group values and fixed nibbles of the control
// symbol decoder.
// assumes: included by bare name, definitions only.
`ifndef RXCD_REGS_SVH
`define RXCD_REGS_SVH

// control code-groups, as they arrive from the descrambler
`define RXCD_CG_IDLE 5'h1F
`define RXCD_CG_J 5'h18
`define RXCD_CG_K 5'h11
`define RXCD_CG_T 5'h0D
`define RXCD_CG_R 5'h07
`define RXCD_CG_H 5'h04

// nibble put out for each half of the start delimiter, and for words without data
`define RXCD_NIB_PREAMBLE 4'h5
`define RXCD_NIB_NONE 4'h0

`endif

// [rxcd_pkg.sv]
// rxcd_pkg.sv: types shared by the control symbol decoder and its test bench.
// assumes: nothing beyond a SystemVerilog compiler.
package rxcd_pkg;

	// one word towards the MAC receive side
	typedef struct packed {
		logic [3:0] nib;
		logic dv;
		logic er;
		logic crs;
	} rxcd_word_s;

	// decoder states, one-hot
	typedef enum logic [5:0] {
		RXCD_ST_IDLE = 6'h01,
		RXCD_ST_LINE = 6'h02,
		RXCD_ST_GOT_J = 6'h04,
		RXCD_ST_PKT = 6'h08,
		RXCD_ST_PKT_I = 6'h10,
		RXCD_ST_GOT_T = 6'h20
	} rxcd_state_e;

endpackage : rxcd_pkg

// [rxcd_buf.sv]
// rxcd_buf.sv: two-entry buffer, output word and skid word.
// assumes: one clock, synchronous active-low reset, valid/ready on both
// sides; all outputs come straight from flip-flops.
`timescale 1ns/100ps
module rxcd_buf #(
	parameter int W = 7
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// filling side
	input wire logic i_valid,
	input wire logic [W-1:0] i_data,
	output logic o_ready,
	// draining side
	output logic o_valid,
	output logic [W-1:0] o_data,
	input wire logic i_ready
);

	logic [W-1:0] skid;
	wire load = i_valid & o_ready;
	wire drain = i_ready | ~o_valid;

	// the skid word keeps the one word that arrives while the output stalls;
	// ready drops only when it is taken, so no word is ever lost
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_valid <= 1'b0;
			o_ready <= 1'b1;
			o_data <= '0;
			skid <= '0;
		end
		else if (drain)
		begin
			o_valid <= ~o_ready | load;
			o_data <= o_ready ? i_data : skid;
			o_ready <= 1'b1;
		end
		else if (load)
		begin
			skid <= i_data;
			o_ready <= 1'b0;
		end
	end

endmodule : rxcd_buf

// [rxcd_decoder.sv]
// rxcd_decoder.sv: receive control code-group decoder for 100BASE-TX.
// assumes: aligned 5-bit code-groups from the descrambler, one per
// accepted cycle; the MAC side drains words through valid/ready.
// reset is synchronous and active low; there are no software registers.
`timescale 1ns/100ps
`include "rxcd_regs.svh"
module rxcd_decoder (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// code-groups from the descrambler
	input wire logic i_cg_valid,
	input wire logic [4:0] i_cg,
	output logic o_cg_ready,
	// words towards the MAC
	output logic o_valid,
	output logic [3:0] o_rxd,
	output logic o_rx_dv,
	output logic o_rx_er,
	output logic o_crs,
	input wire logic i_ready
);

	// data code-group to {ok, nibble}; control and invalid codes give ok=0
	// one table serves the data path and the invalid-code test, so both
	// always agree on which code-groups are data
	function automatic logic [4:0] rxcd_map(input logic [4:0] cg);
		logic [4:0] r;
		r = 5'h00;
		unique case (cg)
			5'h1E: r = 5'h10;
			5'h09: r = 5'h11;
			5'h14: r = 5'h12;
			5'h15: r = 5'h13;
			5'h0A: r = 5'h14;
			5'h0B: r = 5'h15;
			5'h0E: r = 5'h16;
			5'h0F: r = 5'h17;
			5'h12: r = 5'h18;
			5'h13: r = 5'h19;
			5'h16: r = 5'h1A;
			5'h17: r = 5'h1B;
			5'h1A: r = 5'h1C;
			5'h1B: r = 5'h1D;
			5'h1C: r = 5'h1E;
			5'h1D: r = 5'h1F;
			default: r = 5'h00;
		endcase
		return r;
	endfunction : rxcd_map

	// decoder state and the word built for the code-group now offered
	rxcd_pkg::rxcd_state_e state;
	rxcd_pkg::rxcd_state_e next_state;
	rxcd_pkg::rxcd_word_s word;
	rxcd_pkg::rxcd_word_s out_word;
	logic emit;
	logic buf_ready;

	// code-group classification
	wire is_i = i_cg == `RXCD_CG_IDLE;
	wire is_j = i_cg == `RXCD_CG_J;
	wire is_k = i_cg == `RXCD_CG_K;
	wire is_t = i_cg == `RXCD_CG_T;
	wire is_r = i_cg == `RXCD_CG_R;
	wire is_h = i_cg == `RXCD_CG_H;
	wire [4:0] mapped = rxcd_map(i_cg);
	wire is_data = mapped[4];
	wire [3:0] data_nib = mapped[3:0];
	// anything neither data nor a named control code is invalid; this
	// covers 00000-00011, 00101 and the codes no table entry uses
	wire is_bad = ~is_data & ~is_i & ~is_j & ~is_k & ~is_t & ~is_r & ~is_h;
	// a code-group is taken only when the buffer can keep its word, so a
	// stalled MAC back-pressures the descrambler instead of losing words
	wire take = i_cg_valid & buf_ready;
	wire push = take & emit;

	// one word per code-group, except T inside a packet: its meaning is
	// known only with the next code-group, so its word is folded into that one
	always_comb
	begin
		next_state = state;
		emit = 1'b1;
		word = '0;
		word.nib = `RXCD_NIB_NONE;
		unique case (state)
			// outside a packet only a J straight after an idle opens one;
			// a J in line keeps its nibble but carries the error flag
			rxcd_pkg::RXCD_ST_IDLE, rxcd_pkg::RXCD_ST_LINE:
			begin
				if (is_j)
				begin
					word.nib = `RXCD_NIB_PREAMBLE;
					word.er = (state != rxcd_pkg::RXCD_ST_IDLE);
					next_state = (state == rxcd_pkg::RXCD_ST_IDLE) ?
						rxcd_pkg::RXCD_ST_GOT_J : rxcd_pkg::RXCD_ST_LINE;
				end
				else if (is_i)
					next_state = rxcd_pkg::RXCD_ST_IDLE;
				else
				begin
					// misplaced delimiters and error codes outside a packet
					word.er = is_k | is_t | is_r | is_h | is_bad;
					next_state = rxcd_pkg::RXCD_ST_LINE;
				end
			end
			// the K must follow the J at once, or the delimiter is broken
			rxcd_pkg::RXCD_ST_GOT_J:
			begin
				if (is_k)
				begin
					word.nib = `RXCD_NIB_PREAMBLE;
					word.dv = 1'b1;
					word.crs = 1'b1;
					next_state = rxcd_pkg::RXCD_ST_PKT;
				end
				else
				begin
					word.er = 1'b1;
					next_state = is_i ? rxcd_pkg::RXCD_ST_IDLE :
						rxcd_pkg::RXCD_ST_LINE;
				end
			end
			// inside a packet every control code is an error, except T,
			// whose meaning waits for the next code, and a second idle
			rxcd_pkg::RXCD_ST_PKT, rxcd_pkg::RXCD_ST_PKT_I:
			begin
				word.crs = 1'b1;
				word.dv = 1'b1;
				next_state = rxcd_pkg::RXCD_ST_PKT;
				if (is_t)
				begin
					emit = 1'b0;
					next_state = rxcd_pkg::RXCD_ST_GOT_T;
				end
				else if (is_i && state == rxcd_pkg::RXCD_ST_PKT_I)
				begin
					// second idle in a row: the stream ended without T R
					word.crs = 1'b0;
					word.dv = 1'b0;
					next_state = rxcd_pkg::RXCD_ST_IDLE;
				end
				else if (is_i)
				begin
					// first idle is an invalid code in the data, but counted
					word.er = 1'b1;
					next_state = rxcd_pkg::RXCD_ST_PKT_I;
				end
				else if (is_data)
					word.nib = data_nib;
				else
					word.er = 1'b1;
			end
			// the code after T decides: R closes, anything else is an error
			rxcd_pkg::RXCD_ST_GOT_T:
			begin
				if (is_r)
				begin
					word.crs = 1'b0;
					next_state = rxcd_pkg::RXCD_ST_LINE;
				end
				else
				begin
					// lone T: error, the packet goes on; an idle after it
					// still counts as the first of the two that end it
					word.dv = 1'b1;
					word.er = 1'b1;
					word.crs = 1'b1;
					next_state = is_i ? rxcd_pkg::RXCD_ST_PKT_I :
						rxcd_pkg::RXCD_ST_PKT;
				end
			end
			// an upset state code: wait in line for idles before a new J
			default:
				next_state = rxcd_pkg::RXCD_ST_LINE;
		endcase
	end

	// reset lands in line, not idle: a J right after reset lacks its idle
	// state moves only on an accepted code-group
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			state <= rxcd_pkg::RXCD_ST_LINE;
		else if (take)
			state <= next_state;
	end

	// buffer absorbs one stalled word; its ready is our input ready
	// the skid costs one word of storage and keeps ready a register
	rxcd_buf #(
		.W($bits(rxcd_pkg::rxcd_word_s))
	) u_buf (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_valid(push),
		.i_data(word),
		.o_ready(buf_ready),
		.o_valid(o_valid),
		.o_data(out_word),
		.i_ready(i_ready)
	);

	// outputs are the buffer's own flip-flops
	// carrier sense rides in the output word, which reloads whenever the output is free even if no word is pushed, so it can move with o_valid low
	assign o_cg_ready = buf_ready;
	assign o_rxd = out_word.nib;
	assign o_rx_dv = out_word.dv;
	assign o_rx_er = out_word.er;
	assign o_crs = out_word.crs;

endmodule : rxcd_decoder

// [rxcd_decoder_chk.sv]
// rxcd_decoder_chk.sv: port assertions for the control decoder.
// assumes: bound to rxcd_decoder; one clock, sync active-low reset.
`timescale 1ns/100ps
`include "rxcd_regs.svh"
module rxcd_decoder_chk (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// code-group side, watched only
	input wire logic i_cg_valid,
	input wire logic [4:0] i_cg,
	input wire logic o_cg_ready,
	// word side, watched only
	input wire logic o_valid,
	input wire logic [3:0] o_rxd,
	input wire logic o_rx_dv,
	input wire logic o_rx_er,
	input wire logic o_crs,
	input wire logic i_ready
);
	// taken with the output path free, so its word shows next cycle
	wire tk = i_cg_valid & o_cg_ready & i_ready;
	wire ti = tk & (i_cg == `RXCD_CG_IDLE);
	wire tj = tk & (i_cg == `RXCD_CG_J);
	wire tt = tk & (i_cg == `RXCD_CG_T);
	wire tr = tk & (i_cg == `RXCD_CG_R);
	wire td = tk & (i_cg == 5'h1E);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// three idles leave any state idle, a packet included
	sequence s_idle; ti [*3]; endsequence
	sequence s_sof; s_idle ##1 tj ##1 tk && i_cg == `RXCD_CG_K; endsequence
	AST_SSD_J: assert property (s_idle ##1 tj |=> o_valid
		&& o_rxd == 4'h5 && !o_rx_dv && !o_crs) else $error("J");
	AST_SSD_K: assert property (s_sof |=> o_valid && o_rx_dv
		&& o_crs && o_rxd == 4'h5 && !o_rx_er) else $error("K");
	AST_ESD_T: assert property (s_sof ##1 tt |=> !o_valid)
		else $error("T");
	AST_ESD_R: assert property (s_sof ##1 tt ##1 tr |=> o_valid
		&& !o_crs && !o_rx_er) else $error("R");
	AST_BAD: assert property (tk && (i_cg < 5'h04 || i_cg == 5'h05
		|| i_cg == `RXCD_CG_H) |=> o_valid && o_rx_er) else $error("bad");
	AST_CTL_DATA: assert property (s_sof ##1 tj |=> o_valid && o_rx_er
		&& o_crs) else $error("ctl");
	AST_IDLE_END: assert property (s_sof ##1 td ##1 ti ##1 ti |=> o_valid
		&& !o_crs && !o_rx_dv) else $error("idle");
	AST_CRS: assert property (s_sof ##1 td |=> o_valid && o_crs
		&& o_rx_dv && !o_rx_er) else $error("crs");
	AST_ESD_LONE: assert property (s_sof ##1 tt ##1 tk
		&& i_cg != `RXCD_CG_R |=> o_valid && o_rx_er && o_crs)
		else $error("lone T");
	AST_LONE_IDLE: assert property (s_sof ##1 tt ##1 ti ##1 ti
		|=> o_valid && !o_crs && !o_rx_dv) else $error("lone T idle");
endmodule : rxcd_decoder_chk

bind rxcd_decoder rxcd_decoder_chk u_chk (
	.i_clk(i_clk),
	.i_rst_n(i_rst_n),
	.i_cg_valid(i_cg_valid),
	.i_cg(i_cg),
	.o_cg_ready(o_cg_ready),
	.o_valid(o_valid),
	.o_rxd(o_rxd),
	.o_rx_dv(o_rx_dv),
	.o_rx_er(o_rx_er),
	.o_crs(o_crs),
	.i_ready(i_ready)
);

// [rxcd_mac.sv]
// rxcd_mac.sv: receive-side MAC model draining decoder words.
// assumes: a word moves on a rising edge with valid and ready high.
`timescale 1ns/100ps
module rxcd_mac (
	// clock
	input wire logic i_clk,
	// stall request from the bench
	input wire logic i_stall,
	// word handshake
	output logic o_ready
);
	// ready moves only on the edge, never mid-cycle
	initial o_ready = 1'b1;
	always @(posedge i_clk)
		o_ready <= !i_stall;
endmodule : rxcd_mac

// [rxcd_decoder_test.sv]
// rxcd_decoder_test.sv: self-checking bench for the control decoder.
// assumes: rxcd_mac drains words; 250 MHz clock, sync reset.
`timescale 1ns/100ps
`include "rxcd_regs.svh"
module rxcd_decoder_test;
	logic i_clk = 0, i_rst_n = 0, i_cg_valid = 0, stall = 0, slow = 0;
	logic [4:0] i_cg = 5'h00;
	logic o_cg_ready, o_valid, o_rx_dv, o_rx_er, o_crs, i_ready;
	logic [3:0] o_rxd;
	rxcd_pkg::rxcd_word_s got, exp_w, exp_q[$];
	int err_count = 0, checks_done = 0, cyc = 0, seed = 8, k, r;
	logic [3:0] n;
	// data code-group sent for each nibble, as 4B/5B coding defines it
	logic [4:0] cg_tbl [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
		5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
	always #2 i_clk = ~i_clk;
	assign got = {o_rxd, o_rx_dv, o_rx_er, o_crs};
	rxcd_decoder dut (.*);
	rxcd_mac u_mac (.i_clk(i_clk), .i_stall(stall), .o_ready(i_ready));
	task report_and_stop;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	// hold a code-group until taken; note its word when it makes one
	task send(input logic [4:0] c, input logic [6:0] w, input bit e);
		bit rd;
		i_cg_valid = 1;
		i_cg = c;
		if (e)
			exp_q.push_back(w);
		do
		begin
			rd = o_cg_ready;
			@(negedge i_clk);
		end
		while (!rd);
	endtask : send
	task sof;
		repeat (3) send(`RXCD_CG_IDLE, 7'h00, 1);
		send(`RXCD_CG_J, 7'h28, 1);
		send(`RXCD_CG_K, 7'h2D, 1);
	endtask : sof
	// compare words as the MAC takes them; stalls are random when slow
	always @(negedge i_clk)
	begin
		r = $random(seed);
		stall <= slow & r[0];
		if (o_valid && i_ready)
		begin
			exp_w = exp_q.pop_front();
			checks_done++;
			if (got !== exp_w)
			begin
				err_count++;
				$display("MISMATCH word exp %h got %h", exp_w, got);
			end
		end
	end
	// hang guard, far above the fewer than two hundred cycles needed
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			err_count++;
			report_and_stop;
		end
	end
	initial
	begin
		repeat (12) @(negedge i_clk);
		i_rst_n = 1;
		// J without an idle before it keeps nibble 0101, flagged as error
		send(`RXCD_CG_J, 7'h2A, 1);
		send(`RXCD_CG_K, 7'h02, 1);
		send(`RXCD_CG_R, 7'h02, 1);
		sof;
		send(`RXCD_CG_T, 7'h00, 0);
		send(`RXCD_CG_R, 7'h00, 1);
		sof;
		send(`RXCD_CG_J, 7'h07, 1);
		send(`RXCD_CG_H, 7'h07, 1);
		for (k = 0; k < 5; k++)
			send(k < 4 ? k[4:0] : 5'h05, 7'h07, 1);
		send(`RXCD_CG_T, 7'h00, 0);
		send(5'h1E, 7'h07, 1);
		send(`RXCD_CG_IDLE, 7'h07, 1);
		send(`RXCD_CG_IDLE, 7'h00, 1);
		sof;
		send(5'h1E, 7'h05, 1);
		send(`RXCD_CG_IDLE, 7'h07, 1);
		send(`RXCD_CG_IDLE, 7'h00, 1);
		// lone T then idles: error word, and the two idles still end it
		sof;
		send(`RXCD_CG_T, 7'h00, 0);
		send(`RXCD_CG_IDLE, 7'h07, 1);
		send(`RXCD_CG_IDLE, 7'h00, 1);
		slow = 1;
		sof;
		repeat (20 + ($random(seed) & 15))
		begin
			n = 4'($random(seed));
			send(cg_tbl[n], {n, 3'h5}, 1);
		end
		send(`RXCD_CG_T, 7'h00, 0);
		send(`RXCD_CG_R, 7'h00, 1);
		i_cg_valid = 0;
		slow = 0;
		repeat (20) @(negedge i_clk);
		checks_done++;
		if (exp_q.size() != 0)
		begin
			err_count++;
			$display("MISMATCH pending exp 0 got %0d", exp_q.size());
		end
		report_and_stop;
	end
endmodule : rxcd_decoder_test
